//--- rtl/fsc_regs.sv
// Status register and power-on configuration register behind the serial command port
// How it works
// - Status bit 7 set with write-protect pin low locks nonvolatile status bits.
// - Only raising the write-protect pin ends that lock; no command can.
// - Status bit 5 places the protected region at array top (0) or bottom (1).
// - Write-enable latch clears at power-up and gates status writes, program, erase.
// - Status bit 0 reads busy during status write, config write, program, erase.
// - Power-up or reset clears every volatile status bit.
// - Bulk erase runs only when all block-protect bits are zero.
// - Read-status returns the status byte; write-status loads it.
// - Config bits 15:12 set dummy cycles; 0000 and 1111 both mean default.
// - Config bits 11:9 pick power-on execute_in_place read; 101 to 111 disable it.
// - Config bit 4 enables the hold/reset pin function when 1.
// - Config bit 3 low selects quad protocol; high keeps extended SPI.
// - Config bit 2 low selects dual protocol; high keeps extended SPI.
// - Config changes act only from next boot; factory value is all ones.
// - Config register has its own read and write commands.
// - Each boot copies the config register into the working configuration.
// - With config bits 2 and 3 both low, quad wins over dual.
`timescale 1ns/100ps
module fsc_regs #(
  parameter int FRAME_BITS_W = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic boot_req,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  output logic miso,
  output logic miso_oe,
  output logic [7:0] status,
  output logic reject,
  output fsc_pkg::fsc_work_cfg_t work_cfg
);
  import fsc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPCODE = 2'b01,
    ST_BODY = 2'b10,
    ST_READ = 2'b11
  } fsc_state_t;

  // The bit counter must reach the longest command shape
  if (FRAME_BITS_W < 6) begin : g_bad_frame_w
    $error("fsc_regs FRAME_BITS_W must be at least 6");
  end

  fsc_pins_t pins_raw, pins_s;
  logic sclk_q, cs_n_q;
  logic sclk_rise, sclk_fall, frame_end;
  logic [FRAME_BITS_W-1:0] bits_q;
  logic [31:0] rx_q, rx_d;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  fsc_state_t st_q;
  logic rd_cfg_q;
  logic [3:0] rd_idx_q;
  logic [7:0] sr_nv_q;
  logic [7:0] sr_wdata;
  logic [15:0] cfg_q;
  logic [15:0] cfg_wdata, cfg_out;
  logic wel_q, busy_q;
  logic [BUSY_W-1:0] busy_cnt_q, busy_load;
  logic hw_lock, cmd_ok, guard_hit;
  logic [2:0] bp;
  logic do_wren, do_wrdi, do_wrsr, do_wrcfg;
  logic do_prog, do_serase, do_berase;
  logic start_op, refused;

  // Pins come from the host's domain, so every one is synchronised
  assign pins_raw = '{sclk: sclk, cs_n: cs_n, mosi: mosi, wp_n: wp_n};

  fsc_sync #(
    .W($bits(fsc_pins_t)),
    .RST_VAL(PINS_IDLE)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .d(pins_raw),
    .q(pins_s)
  );

  // Previous levels of the synchronised clock and select
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else if (ce) begin
      sclk_q <= pins_s.sclk;
      cs_n_q <= pins_s.cs_n;
    end
  end

  // Edges only count inside a frame; works for both clock idle levels
  assign sclk_rise = pins_s.sclk & ~sclk_q & ~pins_s.cs_n;
  assign sclk_fall = ~pins_s.sclk & sclk_q & ~pins_s.cs_n;
  assign frame_end = pins_s.cs_n & ~cs_n_q;
  assign rx_d = {rx_q[30:0], pins_s.mosi};

  // Input shifter, bit count, opcode and address capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bits_q <= '0;
      rx_q <= 32'h0;
      opcode_q <= 8'h00;
      addr_q <= 24'h0;
    end else if (ce) begin
      if (pins_s.cs_n) begin
        bits_q <= '0;
      end else if (sclk_rise) begin
        rx_q <= rx_d;
        // Saturate so long program data cannot wrap the count
        if (bits_q != '1) begin
          bits_q <= bits_q + 1'b1;
        end
        if (bits_q == FRAME_BITS_W'(BITS_OPCODE - 1)) begin
          opcode_q <= rx_d[7:0];
        end
        if (bits_q == FRAME_BITS_W'(BITS_ADDR_END - 1)) begin
          addr_q <= rx_d[23:0];
        end
      end
    end
  end

  // Frame sequencer: opcode, then either body bits or read-out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      rd_cfg_q <= 1'b0;
    end else if (ce) begin
      if (pins_s.cs_n) begin
        st_q <= ST_IDLE;
      end else begin
        unique case (st_q)
          ST_IDLE: begin
            st_q <= ST_OPCODE;
          end
          ST_OPCODE: begin
            if (sclk_rise && bits_q == FRAME_BITS_W'(BITS_OPCODE - 1)) begin
              if (rx_d[7:0] == OP_RDSR || rx_d[7:0] == OP_RDCFG) begin
                st_q <= ST_READ;
              end else begin
                st_q <= ST_BODY;
              end
              rd_cfg_q <= (rx_d[7:0] == OP_RDCFG);
            end
          end
          ST_BODY, ST_READ: begin
            st_q <= st_q;
          end
        endcase
      end
    end
  end

  // Low byte of the configuration leaves first, each byte MSB first
  assign cfg_out = {cfg_q[7:0], cfg_q[15:8]};

  // Read-out on falling edges; status is live so busy can be polled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
      rd_idx_q <= 4'h0;
    end else if (ce) begin
      if (pins_s.cs_n) begin
        miso_oe <= 1'b0;
        rd_idx_q <= 4'h0;
      end else if (st_q == ST_READ && sclk_fall) begin
        miso_oe <= 1'b1;
        if (rd_cfg_q) begin
          miso <= cfg_out[4'hf - rd_idx_q];
        end else begin
          miso <= status[3'h7 - rd_idx_q[2:0]];
        end
        rd_idx_q <= rd_idx_q + 4'h1;
      end
    end
  end

  // Command qualification at the end of a frame
  assign bp = sr_nv_q[SR_BP_LO +: 3];
  assign hw_lock = sr_nv_q[SR_SRWD] & ~pins_s.wp_n;
  assign cmd_ok = frame_end & ~busy_q;
  assign guard_hit = fsc_in_guard(addr_q, bp, sr_nv_q[SR_TB]);
  assign do_wren = cmd_ok & (opcode_q == OP_WREN) & (bits_q == FRAME_BITS_W'(BITS_OPCODE));
  assign do_wrdi = cmd_ok & (opcode_q == OP_WRDI) & (bits_q == FRAME_BITS_W'(BITS_OPCODE));
  // Every modifying command waits for the latch
  assign do_wrsr = cmd_ok & wel_q & ~hw_lock & (opcode_q == OP_WRSR)
                   & (bits_q == FRAME_BITS_W'(BITS_WRSR));
  assign do_wrcfg = cmd_ok & wel_q & (opcode_q == OP_WRCFG)
                    & (bits_q == FRAME_BITS_W'(BITS_WRCFG));
  assign do_prog = cmd_ok & wel_q & (opcode_q == OP_PROG) & ~guard_hit
                   & (bits_q >= FRAME_BITS_W'(BITS_PROG_MIN));
  assign do_serase = cmd_ok & wel_q & (opcode_q == OP_SERASE) & ~guard_hit
                     & (bits_q == FRAME_BITS_W'(BITS_ADDR_END));
  assign do_berase = cmd_ok & wel_q & (opcode_q == OP_BERASE) & (bp == 3'h0)
                     & (bits_q == FRAME_BITS_W'(BITS_OPCODE));
  assign start_op = do_wrsr | do_wrcfg | do_prog | do_serase | do_berase;

  // A modifying command of at least one whole opcode, sent while not busy, that did not start
  assign refused = cmd_ok & ~start_op & (bits_q >= FRAME_BITS_W'(BITS_OPCODE))
                   & ((opcode_q == OP_WRSR) | (opcode_q == OP_WRCFG) | (opcode_q == OP_PROG)
                      | (opcode_q == OP_SERASE) | (opcode_q == OP_BERASE));

  // Reserved status bits are dropped on the way in
  assign sr_wdata = rx_q[7:0] & SR_NV_MASK;
  // Reserved config bits keep their erased value
  assign cfg_wdata = ({rx_q[7:0], rx_q[15:8]} & ~CFG_RSVD_MASK)
                     | (CFG_FACTORY & CFG_RSVD_MASK);

  // Nonvolatile status bits; reset models a fresh die, not a power cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sr_nv_q <= SR_RESET;
    end else if (ce && do_wrsr) begin
      sr_nv_q <= sr_wdata;
    end
  end

  // Stored power-on configuration; takes effect only at the next boot
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= CFG_FACTORY;
    end else if (ce && do_wrcfg) begin
      cfg_q <= cfg_wdata;
    end
  end

  // Write-enable latch; any started write consumes it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wel_q <= 1'b0;
    end else if (ce) begin
      if (boot_req) begin
        wel_q <= 1'b0;
      end else if (do_wren) begin
        wel_q <= 1'b1;
      end else if (do_wrdi || start_op) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Busy time for the operation being started
  always_comb begin
    busy_load = BUSY_W'(CYC_WRSR);
    if (do_wrcfg) begin
      busy_load = BUSY_W'(CYC_WRCFG);
    end else if (do_prog) begin
      busy_load = BUSY_W'(CYC_PROG);
    end else if (do_serase) begin
      busy_load = BUSY_W'(CYC_SERASE);
    end else if (do_berase) begin
      busy_load = BUSY_W'(CYC_BERASE);
    end
  end

  // Write-in-progress timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (ce) begin
      if (boot_req) begin
        busy_cnt_q <= '0;
        busy_q <= 1'b0;
      end else if (start_op) begin
        busy_cnt_q <= busy_load;
        busy_q <= 1'b1;
      end else if (busy_cnt_q != '0) begin
        busy_cnt_q <= busy_cnt_q - 1'b1;
        busy_q <= (busy_cnt_q != BUSY_W'(1));
      end
    end
  end

  // Refusal flag holds until the next frame ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reject <= 1'b0;
    end else if (ce && frame_end) begin
      reject <= refused;
    end
  end

  // Boot copies stored settings into the working set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      work_cfg <= WORK_CFG_RESET;
    end else if (ce && boot_req) begin
      work_cfg <= fsc_decode_cfg(cfg_q);
    end
  end

  // Each bit straight from a flop; sr_nv_q bit 6 never leaves zero
  assign status = {sr_nv_q[7:2], wel_q, busy_q};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_sr_write(logic lock);
    ce && frame_end && !busy_q && wel_q && opcode_q == OP_WRSR
      && bits_q == FRAME_BITS_W'(BITS_WRSR) && hw_lock == lock;
  endsequence
  sequence s_erase_req(logic [7:0] op);
    ce && frame_end && !busy_q && wel_q && opcode_q == op;
  endsequence
  sequence s_boot;
    ce && boot_req;
  endsequence
  chk_sr_hw_lock: assert property (
    s_sr_write(1'b1) |=> $stable(sr_nv_q) && !busy_q)
    else $error("status write executed while hardware locked");
  chk_lock_release: assert property (
    s_sr_write(1'b0) ##0 pins_s.wp_n |=> sr_nv_q == $past(sr_wdata) && busy_q)
    else $error("status write refused with protect pin high");
  chk_tb_bottom: assert property (
    s_erase_req(OP_SERASE) ##0 bits_q == FRAME_BITS_W'(BITS_ADDR_END) && bp == 3'h1
      && sr_nv_q[SR_TB] && addr_q[SECTOR_LSB +: 5] == 5'h00 |=> !busy_q)
    else $error("erase of bottom protected sector started");
  chk_bp_program: assert property (
    s_erase_req(OP_PROG) ##0 bits_q >= FRAME_BITS_W'(BITS_PROG_MIN) && bp == 3'h1
      && !sr_nv_q[SR_TB] && addr_q[SECTOR_LSB +: 5] == 5'h1f |=> !busy_q)
    else $error("program into protected region started");
  chk_wel_gate: assert property (
    ce && frame_end && !busy_q && !wel_q |=> !busy_q)
    else $error("write started without the enable latch");
  chk_wip_load: assert property (
    s_erase_req(OP_WRCFG) ##0 bits_q == FRAME_BITS_W'(BITS_WRCFG)
      |=> busy_q && busy_cnt_q == BUSY_W'(CYC_WRCFG) ##1 busy_q)
    else $error("config write busy time wrong");
  chk_wip_end: assert property (
    ce && !boot_req && busy_cnt_q == BUSY_W'(1) |=> !busy_q && status[SR_WIP] == 1'b0)
    else $error("busy flag outlived its timer");
  chk_boot_clear: assert property (
    s_boot |=> !wel_q && !busy_q && status[1:0] == 2'b00)
    else $error("volatile status bits survived reset");
  chk_bulk_guard: assert property (
    s_erase_req(OP_BERASE) ##0 bp != 3'h0 |=> !busy_q)
    else $error("bulk erase started with protect bits set");
  chk_cfg_boot: assert property (
    s_boot |=> work_cfg.xip_mode == $past(cfg_q[CFG_XIP_LO +: 3])
      && work_cfg.drv == $past(cfg_q[CFG_DRV_LO +: 3])
      && work_cfg.hold_en == $past(cfg_q[CFG_HOLD]))
    else $error("boot did not copy stored configuration");
  chk_cfg_deferred: assert property (
    !(ce && boot_req) |=> $stable(work_cfg))
    else $error("working configuration changed outside boot");
  chk_quad_first: assert property (
    s_boot ##0 cfg_q[CFG_QUAD] == 1'b0 && cfg_q[CFG_DUAL] == 1'b0
      |=> work_cfg.proto == PROTO_QUAD)
    else $error("dual chosen over quad");
  chk_dummy_default: assert property (
    s_boot ##0 cfg_q[CFG_DUMMY_LO +: 4] == 4'h0 |=> work_cfg.dummy == DUMMY_DEFAULT)
    else $error("zero dummy code not mapped to default");

endmodule : fsc_regs

//--- include/fsc_pkg.sv
// Constants, types and helpers for the flash status and power-on configuration block
package fsc_pkg;

  // Core clock rate
  localparam int CLK_MHZ = 250;

  // Command codes, one byte each
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_RDCFG = 8'hb5;
  localparam logic [7:0] OP_WRCFG = 8'hb1;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SERASE = 8'hd8;
  localparam logic [7:0] OP_BERASE = 8'hc7;

  // Serial bit counts that make a command complete
  localparam int BITS_OPCODE = 8;
  localparam int BITS_ADDR_END = 32;
  localparam int BITS_WRSR = 16;
  localparam int BITS_WRCFG = 24;
  localparam int BITS_PROG_MIN = 40;

  // Status register layout
  localparam int SR_WIP = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_TB = 5;
  localparam int SR_SRWD = 7;
  localparam logic [7:0] SR_NV_MASK = 8'hbc;
  localparam logic [7:0] SR_RESET = 8'h00;

  // Power-on configuration layout
  localparam int CFG_DUMMY_LO = 12;
  localparam int CFG_XIP_LO = 9;
  localparam int CFG_DRV_LO = 6;
  localparam int CFG_HOLD = 4;
  localparam int CFG_QUAD = 3;
  localparam int CFG_DUAL = 2;
  localparam logic [15:0] CFG_FACTORY = 16'hffff;
  localparam logic [15:0] CFG_RSVD_MASK = 16'h0023;
  localparam logic [3:0] DUMMY_DEFAULT = 4'hf;
  localparam logic [2:0] XIP_LAST_MODE = 3'h4;

  // Array geometry: 32 sectors of 64 KB
  localparam int SECTOR_LSB = 16;
  localparam logic [5:0] NUM_SECTORS = 6'h20;

  // Busy times in ns and their cycle counts
  localparam int T_WRSR_NS = 1500;
  localparam int T_WRCFG_NS = 2000;
  localparam int T_PROG_NS = 3000;
  localparam int T_SERASE_NS = 6000;
  localparam int T_BERASE_NS = 12000;
  localparam int CYC_WRSR = (T_WRSR_NS * CLK_MHZ) / 1000;
  localparam int CYC_WRCFG = (T_WRCFG_NS * CLK_MHZ) / 1000;
  localparam int CYC_PROG = (T_PROG_NS * CLK_MHZ) / 1000;
  localparam int CYC_SERASE = (T_SERASE_NS * CLK_MHZ) / 1000;
  localparam int CYC_BERASE = (T_BERASE_NS * CLK_MHZ) / 1000;
  localparam int BUSY_W = 12;

  typedef enum logic [1:0] {
    PROTO_EXT = 2'b00,
    PROTO_DUAL = 2'b01,
    PROTO_QUAD = 2'b10
  } fsc_proto_t;

  // Working configuration seen by the rest of the device
  typedef struct packed {
    logic [3:0] dummy;
    logic [2:0] xip_mode;
    logic xip_en;
    logic [2:0] drv;
    logic hold_en;
    fsc_proto_t proto;
  } fsc_work_cfg_t;

  // Serial pins as one bundle
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic wp_n;
  } fsc_pins_t;

  localparam fsc_pins_t PINS_IDLE = 4'h5;

  // Expand the stored configuration into working settings
  function automatic fsc_work_cfg_t fsc_decode_cfg(input logic [15:0] c);
    fsc_work_cfg_t w;
    w.dummy = (c[CFG_DUMMY_LO +: 4] == 4'h0) ? DUMMY_DEFAULT : c[CFG_DUMMY_LO +: 4];
    w.xip_mode = c[CFG_XIP_LO +: 3];
    w.xip_en = (c[CFG_XIP_LO +: 3] <= XIP_LAST_MODE);
    w.drv = c[CFG_DRV_LO +: 3];
    w.hold_en = c[CFG_HOLD];
    // Quad beats dual when both are asked for
    w.proto = !c[CFG_QUAD] ? PROTO_QUAD : (!c[CFG_DUAL] ? PROTO_DUAL : PROTO_EXT);
    return w;
  endfunction : fsc_decode_cfg

  // Working settings right after power-on, before any boot request
  localparam fsc_work_cfg_t WORK_CFG_RESET = fsc_decode_cfg(CFG_FACTORY);

  // True when an address falls inside the block-protected region
  function automatic logic fsc_in_guard(input logic [23:0] addr, input logic [2:0] bp,
                                        input logic tb);
    logic [5:0] span;
    logic [5:0] sect;
    span = 6'h0;
    sect = {1'b0, addr[SECTOR_LSB +: 5]};
    if (bp != 3'h0) begin
      span = (bp >= 3'h6) ? NUM_SECTORS : 6'(1 << (bp - 3'h1));
    end
    return (span != 6'h0) && (tb ? (sect < span) : (sect >= (NUM_SECTORS - span)));
  endfunction : fsc_in_guard

endpackage : fsc_pkg

//--- rtl/fsc_sync.sv
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/100ps
module fsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_width
    $error("fsc_sync width must be at least one");
  end

  // First stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : fsc_sync

//--- bench/fsc_host_model.sv
// Behavioural serial host that frames register commands for the block
`timescale 1ns/100ps
module fsc_host_model
  import fsc_pkg::*;
(
  input wire logic clk,
  input wire logic miso,
  input wire logic miso_oe,
  output fsc_pkg::fsc_pins_t pins,
  output logic [7:0] rx_byte,
  output logic rx_stb
);
  // Idle pins: clock low, deselected, write-protect released
  initial begin
    pins = PINS_IDLE;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
  end

  // Mode 0 frame, 64 ns serial period; nb command bits MSB first, then nrd bytes read back
  // Serial clock slow enough for the two-flop synchroniser to see every edge
  task automatic frame(input logic [47:0] d, input int nb, input int nrd);
    @(posedge clk);
    #1 pins.cs_n = 1'b0;
    #32;
    for (int i = nb + 8 * nrd - 1; i >= 0; i--) begin
      // Read phase toggles the data line so a stale value never looks valid
      pins.mosi = (i >= 8 * nrd) ? d[i - 8 * nrd] : ~pins.mosi;
      #32 pins.sclk = 1'b1;
      if (i < 8 * nrd) begin
        rx_byte = {rx_byte[6:0], miso_oe ? miso : 1'bx};
        if (i % 8 == 0) rx_stb = ~rx_stb;
      end
      #32 pins.sclk = 1'b0;
    end
    #32 pins.cs_n = 1'b1;
    pins.mosi = ~pins.mosi;
    // Gap long enough for the frame end to be executed
    #40;
  endtask : frame

  // Write-protect pin level, changed just after a clock edge
  task automatic set_wp(input logic v);
    @(posedge clk);
    #1 pins.wp_n = v;
  endtask : set_wp
endmodule : fsc_host_model

//--- bench/fsc_regs_tb.sv
// Self-checking bench for the status and power-on configuration registers
`timescale 1ns/100ps
module fsc_regs_tb;
  import fsc_pkg::*;
  logic clk;
  logic arst_n;
  logic boot_req;
  logic ce;
  fsc_pins_t pins;
  logic miso;
  logic miso_oe;
  logic [7:0] status;
  logic reject;
  fsc_work_cfg_t work_cfg;
  logic [7:0] rx_byte;
  logic rx_stb;
  logic [7:0] exp_q[$];
  logic [7:0] sr_e;
  logic [15:0] cfg_v;
  logic [15:0] cfg_e;
  int n_fail;
  int checks_done;
  int seed;

  fsc_regs dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .boot_req(boot_req),
    .sclk(pins.sclk), .cs_n(pins.cs_n), .mosi(pins.mosi), .wp_n(pins.wp_n),
    .miso(miso), .miso_oe(miso_oe), .status(status), .reject(reject),
    .work_cfg(work_cfg));
  fsc_host_model host_u (.clk(clk), .miso(miso), .miso_oe(miso_oe), .pins(pins),
    .rx_byte(rx_byte), .rx_stb(rx_stb));

  // 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out();
    if (n_fail == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Working settings worked out independently from a stored value
  function automatic fsc_work_cfg_t exp_cfg(input logic [15:0] c);
    exp_cfg.dummy = (c[15:12] == 4'h0) ? 4'hf : c[15:12];
    exp_cfg.xip_mode = c[11:9];
    exp_cfg.xip_en = c[11:9] < 3'h5;
    exp_cfg.drv = c[8:6];
    exp_cfg.hold_en = c[4];
    exp_cfg.proto = !c[3] ? PROTO_QUAD : (!c[2] ? PROTO_DUAL : PROTO_EXT);
  endfunction : exp_cfg

  // Bounded wait for ready; busy length checked against the set time
  task automatic wait_idle(input int cyc);
    int n;
    n = 0;
    while (status[SR_WIP] !== 1'b0) begin
      @(posedge clk);
      #1 n++;
      if (n > 4000) begin
        n_fail++;
        $display("wrong value at %0t: busy never cleared", $time);
        close_out();
      end
    end
    chk(n > cyc - 20 && n <= cyc, 1'b1, "busy time");
  endtask : wait_idle

  task automatic rd_sr(input logic [7:0] e);
    exp_q.push_back(e);
    exp_q.push_back(e);
    host_u.frame(48'(OP_RDSR), 8, 2);
    chk(miso_oe, 1'b0, "output released");
  endtask : rd_sr

  task automatic rd_cfg(input logic [15:0] e);
    exp_q.push_back(e[7:0]);
    exp_q.push_back(e[15:8]);
    host_u.frame(48'(OP_RDCFG), 8, 2);
  endtask : rd_cfg

  // Latch then status write; ok says whether it must run
  task automatic wr_sr(input logic [7:0] d, input logic ok);
    host_u.frame(48'(OP_WREN), 8, 0);
    host_u.frame({32'h0, OP_WRSR, d}, 16, 0);
    chk(reject, !ok, "status write refusal");
    if (ok) begin
      sr_e = (d & SR_NV_MASK) | 8'h01;
      chk(status, sr_e, "status write start");
      wait_idle(CYC_WRSR);
      sr_e[SR_WIP] = 1'b0;
    end else sr_e[SR_WEL] = 1'b1;
    chk(status, sr_e, "status after write");
  endtask : wr_sr

  task automatic wr_op(input logic [47:0] d, input int nb, input logic ok, input int cyc);
    host_u.frame(48'(OP_WREN), 8, 0);
    host_u.frame(d, nb, 0);
    chk(reject, !ok, "op refusal");
    chk(status[1:0], ok ? 2'b01 : 2'b10, "op flags");
    if (ok) wait_idle(cyc);
  endtask : wr_op

  task automatic boot();
    @(posedge clk);
    #1 boot_req = 1'b1;
    @(posedge clk);
    #1 boot_req = 1'b0;
    repeat (2) @(posedge clk);
  endtask : boot

  // Each finished read-back byte is matched against the oldest note
  initial begin
    #1;
    forever begin
      @(rx_stb);
      chk({8'h00, rx_byte}, {8'h00, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx}, "read");
    end
  end

  // Main sequence
  initial begin
    seed = 32'h687e28e7;
    arst_n = 1'b0;
    boot_req = 1'b0;
    ce = 1'b1;
    n_fail = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    chk(status, SR_RESET, "reset status");
    chk(work_cfg, exp_cfg(CFG_FACTORY), "reset cfg");
    rd_cfg(CFG_FACTORY);
    // Status write with no latch set must not run
    host_u.frame({32'h0, OP_WRSR, 8'h9c}, 16, 0);
    chk(reject, 1'b1, "no latch");
    rd_sr(8'h00);
    // Lock bit plus low write-protect pin; no command unlocks
    wr_sr(8'h80 | 8'($random(seed)), 1'b1);
    host_u.set_wp(1'b0);
    wr_sr(8'h00, 1'b0);
    host_u.frame(48'(OP_WRDI), 8, 0);
    chk(status[SR_WEL], 1'b0, "latch off");
    wr_sr(8'h00, 1'b0);
    host_u.set_wp(1'b1);
    wr_sr(8'h44, 1'b1);
    // One guarded sector at the top, then at the bottom
    wr_op({OP_PROG, 24'h1f0000, 8'h5a}, 40, 1'b0, 0);
    wr_op({OP_PROG, 24'h1e0000, 8'h5a}, 40, 1'b1, CYC_PROG);
    wr_op(48'(OP_BERASE), 8, 1'b0, 0);
    wr_sr(8'h24, 1'b1);
    wr_op({16'h0, OP_SERASE, 24'h000000}, 32, 1'b0, 0);
    wr_op({16'h0, OP_SERASE, 24'h1f0000}, 32, 1'b1, CYC_SERASE);
    wr_sr(8'h00, 1'b1);
    wr_op(48'(OP_BERASE), 8, 1'b1, CYC_BERASE);
    // Stored config reaches the working settings only at boot
    cfg_e = CFG_FACTORY;
    for (int k = 0; k < 8; k++) begin
      cfg_v = 16'($random(seed));
      cfg_v[11:9] = 3'(k);
      cfg_v[3:2] = 2'(k);
      if (k == 0) cfg_v[15:12] = 4'h0;
      host_u.frame(48'(OP_WREN), 8, 0);
      host_u.frame({24'h0, OP_WRCFG, cfg_v[7:0], cfg_v[15:8]}, 24, 0);
      chk(status[0], 1'b1, "cfg busy");
      wait_idle(CYC_WRCFG);
      chk(work_cfg, exp_cfg(cfg_e), "cfg before boot");
      cfg_e = cfg_v | CFG_RSVD_MASK;
      rd_cfg(cfg_e);
      boot();
      chk(work_cfg, exp_cfg(cfg_e), "cfg after boot");
    end
    // Boot drops the volatile latch
    host_u.frame(48'(OP_WREN), 8, 0);
    boot();
    chk(status[1:0], 2'b00, "volatile after boot");
    // Clock enable low freezes the busy timer, which then resumes where it stopped
    host_u.frame(48'(OP_WREN), 8, 0);
    host_u.frame({32'h0, OP_WRSR, 8'h00}, 16, 0);
    ce = 1'b0;
    repeat (400) @(posedge clk);
    #1 chk(status[SR_WIP], 1'b1, "frozen busy");
    ce = 1'b1;
    wait_idle(CYC_WRSR);
    repeat (20) @(posedge clk);
    close_out();
  end
endmodule : fsc_regs_tb
